// file: scr_regs.svh
// offsets, reset values, field masks and timing of the sensor config bank
`ifndef SCR_REGS_SVH
`define SCR_REGS_SVH

// ----------------------------------------------------------------------
// group selection and soft reset
// ----------------------------------------------------------------------
`define SCR_O_GRP     8'h03
`define SCR_R_GRP     8'h00
`define SCR_GROUP_A   8'h00
`define SCR_O_SRST    8'h20
`define SCR_SRST_BIT  0

// ----------------------------------------------------------------------
// offsets of the group A bank
// ----------------------------------------------------------------------
`define SCR_O_FLIP    8'h05
`define SCR_O_LLH     8'h06
`define SCR_O_LLL     8'h07
`define SCR_O_FLH     8'h08
`define SCR_O_FLL     8'h09
`define SCR_O_SER     8'h1a
`define SCR_O_PAD1    8'h23
`define SCR_O_PAD2    8'h24
`define SCR_O_PAD3    8'h25
`define SCR_O_PAD4    8'h26
`define SCR_O_PAD5    8'h27
`define SCR_O_SYN     8'h4e
`define SCR_O_TGM     8'h51
`define SCR_O_TGD     8'h52
`define SCR_O_LKM     8'h53
`define SCR_O_LKD     8'h54
`define SCR_O_DIV1    8'h56
`define SCR_O_DIV2    8'h57
`define SCR_O_DIV3    8'h58
`define SCR_O_BEH     8'h63
`define SCR_O_BEL     8'h64
`define SCR_O_BSH     8'h65
`define SCR_O_BSL     8'h66
`define SCR_O_AEH     8'h67
`define SCR_O_AEL     8'h68
`define SCR_O_ASH     8'h69
`define SCR_O_ASL     8'h6a

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define SCR_R_FLIP    8'h00
`define SCR_R_LLH     8'h08
`define SCR_R_LLL     8'h97
`define SCR_R_FLH     8'h04
`define SCR_R_FLL     8'h7c
`define SCR_R_SER     8'h50
`define SCR_R_PAD1    8'h60
`define SCR_R_PADX    8'h00
`define SCR_R_SYN     8'h7a
`define SCR_R_MUL     8'h2c
`define SCR_R_DIVF    8'h04
`define SCR_R_DIV1    8'h20
`define SCR_R_DIV2    8'h50
`define SCR_R_DIV3    8'hf3
`define SCR_R_BEH     8'h0b
`define SCR_R_BEL     8'h60
`define SCR_R_BSH     8'h0a
`define SCR_R_BSL     8'hb0
`define SCR_R_AEH     8'h09
`define SCR_R_AEL     8'hd0
`define SCR_R_ASH     8'h08
`define SCR_R_ASL     8'h00

// ----------------------------------------------------------------------
// field masks and timing
// ----------------------------------------------------------------------
`define SCR_M_FULL    8'hff
`define SCR_M_W5      8'h1f
`define SCR_M_W4      8'h0f
`define SCR_M_W2      8'h03
`define SCR_CLK_NS    8
`define SCR_SRST_NS   800
`define SCR_SRST_CYC  ((`SCR_SRST_NS + `SCR_CLK_NS - 1) / `SCR_CLK_NS)

`endif

// file: scr_pkg.sv
// types shared by the sensor config bank
package scr_pkg;

    // --------------------------------------------------------------------
    // soft reset sequencer states, gray along idle-hold-done
    // --------------------------------------------------------------------
    typedef enum logic [1:0] {
        SCR_IDLE = 2'b00,
        SCR_HOLD = 2'b01,
        SCR_DONE = 2'b11
    } scr_srst_e;

    typedef logic [7:0] scr_byte_t;

endpackage : scr_pkg

// file: scr_soft_reset_seq.sv
// self-clearing software reset sequencer
`timescale 1ns/1ps
`include "scr_regs.svh"

module scr_soft_reset_seq (
    // clock and reset
    input  logic clk_sys_i,
    input  logic resetn_i,
    // request from the register bank
    input  logic start_i,
    // state towards the bank and the device
    output logic busy_o,
    output logic soft_reset_o
);

    localparam logic [7:0] HOLD_CYC = 8'(`SCR_SRST_CYC);

    scr_pkg::scr_srst_e state;
    scr_pkg::scr_srst_e next_state;
    logic [7:0]         cnt;
    logic [7:0]         next_cnt;

    // a start seen in the done cycle restarts the hold, set wins
    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        unique case (state)
            scr_pkg::SCR_IDLE: begin
                next_cnt = 8'h00;
                if (start_i) next_state = scr_pkg::SCR_HOLD;
            end
            scr_pkg::SCR_HOLD: begin
                next_cnt = cnt + 8'h01;
                if (cnt == HOLD_CYC - 8'h01) next_state = scr_pkg::SCR_DONE;
            end
            scr_pkg::SCR_DONE: begin
                next_cnt = 8'h00;
                next_state = start_i ? scr_pkg::SCR_HOLD
                                     : scr_pkg::SCR_IDLE;
            end
            default: begin
                next_cnt   = 8'h00;
                next_state = scr_pkg::SCR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state <= scr_pkg::SCR_IDLE;
            cnt   <= 8'h00;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
        end
    end

    assign busy_o       = (state != scr_pkg::SCR_IDLE);
    assign soft_reset_o = (state == scr_pkg::SCR_HOLD);

endmodule : scr_soft_reset_seq

// file: scr_config_regs.sv
// group A configuration register bank of the image sensor core
// Function
// - an 8-bit group selector at 03 picks the group later accesses reach and resets to zero.
// - the flip field at 05 gives vertical inversion on bit 1 and horizontal on bit 0, both clear at reset.
// - writing one to bit 0 of 20 starts a soft reset and the bit clears itself when it completes.
// - the timing synthesizer takes its multiplier from 51 and its 5-bit divider from 52.
// - the link synthesizer takes its multiplier from 53 and its 5-bit divider from 54.
// - each 12-bit sync code joins a 4-bit high field with the 8-bit low byte at the next address.
`timescale 1ns/1ps
`include "scr_regs.svh"

module scr_config_regs (
    // clock and reset
    input  logic        clk_sys_i,
    input  logic        resetn_i,
    // register port
    input  logic [7:0]  addr_i,
    input  logic [7:0]  wdata_i,
    input  logic        wr_i,
    input  logic        rd_i,
    output logic [7:0]  rdata_o,
    // group and reset
    output logic [7:0]  group_select_o,
    output logic        soft_reset_o,
    // image geometry
    output logic        vflip_o,
    output logic        hflip_o,
    output logic [12:0] line_length_o,
    output logic [12:0] frame_lines_o,
    // control port and pads
    output logic [7:0]  serial_port_ctrl_o,
    output logic [7:0]  pad_config_1_o,
    output logic [7:0]  pad_config_2_o,
    output logic [7:0]  pad_config_3_o,
    output logic [7:0]  pad_config_4_o,
    output logic [7:0]  pad_config_5_o,
    // clock synthesizers and dividers
    output logic [7:0]  clock_synth_ctrl_o,
    output logic [7:0]  timing_synth_multiplier_o,
    output logic [4:0]  timing_synth_divider_o,
    output logic [7:0]  link_synth_multiplier_o,
    output logic [4:0]  link_synth_divider_o,
    output logic [7:0]  clock_divider_1_o,
    output logic [7:0]  clock_divider_2_o,
    output logic [7:0]  clock_divider_3_o,
    // sync codes
    output logic [11:0] blank_end_code_o,
    output logic [11:0] blank_start_code_o,
    output logic [11:0] active_end_code_o,
    output logic [11:0] active_start_code_o
);

    // ------------------------------------------------------------------
    // slot numbers of the bank storage
    // ------------------------------------------------------------------
    localparam int NSLOT = 27;

    localparam logic [4:0] S_FLIP = 5'd0;
    localparam logic [4:0] S_LLH  = 5'd1;
    localparam logic [4:0] S_LLL  = 5'd2;
    localparam logic [4:0] S_FLH  = 5'd3;
    localparam logic [4:0] S_FLL  = 5'd4;
    localparam logic [4:0] S_SER  = 5'd5;
    localparam logic [4:0] S_PAD1 = 5'd6;
    localparam logic [4:0] S_PAD2 = 5'd7;
    localparam logic [4:0] S_PAD3 = 5'd8;
    localparam logic [4:0] S_PAD4 = 5'd9;
    localparam logic [4:0] S_PAD5 = 5'd10;
    localparam logic [4:0] S_SYN  = 5'd11;
    localparam logic [4:0] S_TGM  = 5'd12;
    localparam logic [4:0] S_TGD  = 5'd13;
    localparam logic [4:0] S_LKM  = 5'd14;
    localparam logic [4:0] S_LKD  = 5'd15;
    localparam logic [4:0] S_DIV1 = 5'd16;
    localparam logic [4:0] S_DIV2 = 5'd17;
    localparam logic [4:0] S_DIV3 = 5'd18;
    localparam logic [4:0] S_BEH  = 5'd19;
    localparam logic [4:0] S_BEL  = 5'd20;
    localparam logic [4:0] S_BSH  = 5'd21;
    localparam logic [4:0] S_BSL  = 5'd22;
    localparam logic [4:0] S_AEH  = 5'd23;
    localparam logic [4:0] S_AEL  = 5'd24;
    localparam logic [4:0] S_ASH  = 5'd25;
    localparam logic [4:0] S_ASL  = 5'd26;

    // ------------------------------------------------------------------
    // address to slot, hit flag in the top bit
    // ------------------------------------------------------------------
    function automatic logic [5:0] slot_of(input logic [7:0] a);
        logic [5:0] s;
        s = 6'h00;
        case (a)
            `SCR_O_FLIP: s = {1'b1, S_FLIP};
            `SCR_O_LLH:  s = {1'b1, S_LLH};
            `SCR_O_LLL:  s = {1'b1, S_LLL};
            `SCR_O_FLH:  s = {1'b1, S_FLH};
            `SCR_O_FLL:  s = {1'b1, S_FLL};
            `SCR_O_SER:  s = {1'b1, S_SER};
            `SCR_O_PAD1: s = {1'b1, S_PAD1};
            `SCR_O_PAD2: s = {1'b1, S_PAD2};
            `SCR_O_PAD3: s = {1'b1, S_PAD3};
            `SCR_O_PAD4: s = {1'b1, S_PAD4};
            `SCR_O_PAD5: s = {1'b1, S_PAD5};
            `SCR_O_SYN:  s = {1'b1, S_SYN};
            `SCR_O_TGM:  s = {1'b1, S_TGM};
            `SCR_O_TGD:  s = {1'b1, S_TGD};
            `SCR_O_LKM:  s = {1'b1, S_LKM};
            `SCR_O_LKD:  s = {1'b1, S_LKD};
            `SCR_O_DIV1: s = {1'b1, S_DIV1};
            `SCR_O_DIV2: s = {1'b1, S_DIV2};
            `SCR_O_DIV3: s = {1'b1, S_DIV3};
            `SCR_O_BEH:  s = {1'b1, S_BEH};
            `SCR_O_BEL:  s = {1'b1, S_BEL};
            `SCR_O_BSH:  s = {1'b1, S_BSH};
            `SCR_O_BSL:  s = {1'b1, S_BSL};
            `SCR_O_AEH:  s = {1'b1, S_AEH};
            `SCR_O_AEL:  s = {1'b1, S_AEL};
            `SCR_O_ASH:  s = {1'b1, S_ASH};
            `SCR_O_ASL:  s = {1'b1, S_ASL};
            default:     s = 6'h00;
        endcase
        return s;
    endfunction : slot_of

    // ------------------------------------------------------------------
    // reset value of each slot
    // ------------------------------------------------------------------
    function automatic scr_pkg::scr_byte_t slot_reset(input logic [4:0] i);
        scr_pkg::scr_byte_t r;
        r = `SCR_R_PADX;
        case (i)
            S_FLIP:  r = `SCR_R_FLIP;
            S_LLH:   r = `SCR_R_LLH;
            S_LLL:   r = `SCR_R_LLL;
            S_FLH:   r = `SCR_R_FLH;
            S_FLL:   r = `SCR_R_FLL;
            S_SER:   r = `SCR_R_SER;
            S_PAD1:  r = `SCR_R_PAD1;
            S_SYN:   r = `SCR_R_SYN;
            S_TGM:   r = `SCR_R_MUL;
            S_TGD:   r = `SCR_R_DIVF;
            S_LKM:   r = `SCR_R_MUL;
            S_LKD:   r = `SCR_R_DIVF;
            S_DIV1:  r = `SCR_R_DIV1;
            S_DIV2:  r = `SCR_R_DIV2;
            S_DIV3:  r = `SCR_R_DIV3;
            S_BEH:   r = `SCR_R_BEH;
            S_BEL:   r = `SCR_R_BEL;
            S_BSH:   r = `SCR_R_BSH;
            S_BSL:   r = `SCR_R_BSL;
            S_AEH:   r = `SCR_R_AEH;
            S_AEL:   r = `SCR_R_AEL;
            S_ASH:   r = `SCR_R_ASH;
            S_ASL:   r = `SCR_R_ASL;
            default: r = `SCR_R_PADX;
        endcase
        return r;
    endfunction : slot_reset

    // ------------------------------------------------------------------
    // implemented bits of each slot, the rest read as zero
    // ------------------------------------------------------------------
    function automatic scr_pkg::scr_byte_t slot_mask(input logic [4:0] i);
        scr_pkg::scr_byte_t m;
        m = `SCR_M_FULL;
        case (i)
            S_FLIP:  m = `SCR_M_W2;
            S_LLH:   m = `SCR_M_W5;
            S_FLH:   m = `SCR_M_W5;
            S_TGD:   m = `SCR_M_W5;
            S_LKD:   m = `SCR_M_W5;
            S_BEH:   m = `SCR_M_W4;
            S_BSH:   m = `SCR_M_W4;
            S_AEH:   m = `SCR_M_W4;
            S_ASH:   m = `SCR_M_W4;
            default: m = `SCR_M_FULL;
        endcase
        return m;
    endfunction : slot_mask

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    logic [7:0]         group_select;
    scr_pkg::scr_byte_t cfg [NSLOT];
    logic [7:0]         next_rdata;
    logic               srst_busy;

    wire        grp_a    = (group_select == `SCR_GROUP_A);
    wire        grp_hit  = (addr_i == `SCR_O_GRP);
    wire        srst_hit = grp_a && (addr_i == `SCR_O_SRST);
    wire [5:0]  slot     = slot_of(addr_i);
    wire        bank_hit = grp_a && slot[5];
    wire [4:0]  slot_idx = slot[4:0];
    wire        srst_go  = wr_i && srst_hit && wdata_i[`SCR_SRST_BIT];

    // ------------------------------------------------------------------
    // group selector, reachable from every group
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            group_select <= `SCR_R_GRP;
        end else if (wr_i && grp_hit) begin
            group_select <= wdata_i;
        end
    end

    // ------------------------------------------------------------------
    // bank storage
    // ------------------------------------------------------------------
    for (genvar g = 0; g < NSLOT; g++) begin : g_slot
        localparam logic [4:0] IDX = 5'(g);
        localparam scr_pkg::scr_byte_t RV = slot_reset(IDX);
        localparam scr_pkg::scr_byte_t MK = slot_mask(IDX);
        wire hit = wr_i && bank_hit && (slot_idx == IDX);

        always_ff @(posedge clk_sys_i or negedge resetn_i) begin
            if (!resetn_i) begin
                cfg[g] <= RV;
            end else if (hit) begin
                cfg[g] <= wdata_i & MK;
            end
        end
    end

    // ------------------------------------------------------------------
    // soft reset
    // ------------------------------------------------------------------
    scr_soft_reset_seq u_srst (
        .clk_sys_i    (clk_sys_i),
        .resetn_i     (resetn_i),
        .start_i      (srst_go),
        .busy_o       (srst_busy),
        .soft_reset_o (soft_reset_o)
    );

    // ------------------------------------------------------------------
    // read path, data valid the cycle after the strobe only
    // ------------------------------------------------------------------
    wire [7:0] srst_rd  = {7'h00, srst_busy};
    wire [7:0] bank_rd  = cfg[slot_idx];
    wire [7:0] sel_rd   = grp_hit  ? group_select :
                          srst_hit ? srst_rd      :
                          bank_hit ? bank_rd      : 8'h00;

    assign next_rdata = rd_i ? sel_rd : 8'h00;

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_o <= 8'h00;
        end else begin
            rdata_o <= next_rdata;
        end
    end

    // ------------------------------------------------------------------
    // configuration outputs
    // ------------------------------------------------------------------
    assign group_select_o = group_select;

    assign vflip_o = cfg[S_FLIP][1];
    assign hflip_o = cfg[S_FLIP][0];

    // the host must keep both above the active window
    assign line_length_o = {cfg[S_LLH][4:0], cfg[S_LLL]};
    assign frame_lines_o = {cfg[S_FLH][4:0], cfg[S_FLL]};

    assign serial_port_ctrl_o = cfg[S_SER];
    assign pad_config_1_o     = cfg[S_PAD1];
    assign pad_config_2_o     = cfg[S_PAD2];
    assign pad_config_3_o     = cfg[S_PAD3];
    assign pad_config_4_o     = cfg[S_PAD4];
    assign pad_config_5_o     = cfg[S_PAD5];

    assign clock_synth_ctrl_o        = cfg[S_SYN];
    assign timing_synth_multiplier_o = cfg[S_TGM];
    assign timing_synth_divider_o    = cfg[S_TGD][4:0];
    assign link_synth_multiplier_o   = cfg[S_LKM];
    assign link_synth_divider_o      = cfg[S_LKD][4:0];
    assign clock_divider_1_o         = cfg[S_DIV1];
    assign clock_divider_2_o         = cfg[S_DIV2];
    assign clock_divider_3_o         = cfg[S_DIV3];

    assign blank_end_code_o    = {cfg[S_BEH][3:0], cfg[S_BEL]};
    assign blank_start_code_o  = {cfg[S_BSH][3:0], cfg[S_BSL]};
    assign active_end_code_o   = {cfg[S_AEH][3:0], cfg[S_AEL]};
    assign active_start_code_o = {cfg[S_ASH][3:0], cfg[S_ASL]};

endmodule : scr_config_regs

// file: scr_config_regs_assertions.sv
// concurrent checks on the sensor config register bank ports
`timescale 1ns/1ps
`include "scr_regs.svh"

module scr_config_regs_assertions (
    // clock and reset
    input wire logic        clk_sys_i,
    input wire logic        resetn_i,
    // register port
    input wire logic [7:0]  addr_i,
    input wire logic [7:0]  wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [7:0]  rdata_o,
    // watched outputs
    input wire logic [7:0]  group_select_o,
    input wire logic        soft_reset_o,
    input wire logic        vflip_o,
    input wire logic        hflip_o,
    input wire logic [7:0]  timing_synth_multiplier_o,
    input wire logic [4:0]  timing_synth_divider_o,
    input wire logic [7:0]  link_synth_multiplier_o,
    input wire logic [11:0] blank_end_code_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);

    // ------------------------------------------------------------------
    // helper logic
    // ------------------------------------------------------------------
    logic [7:0] srst_cnt;
    wire        grp_a = group_select_o == `SCR_GROUP_A;
    wire        wr_a  = wr_i && grp_a;
    wire        far   = !grp_a && addr_i != `SCR_O_GRP;

    // counts the high cycles of the current soft reset
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            srst_cnt <= 8'h00;
        end else if (soft_reset_o) begin
            srst_cnt <= srst_cnt + 8'h01;
        end else begin
            srst_cnt <= 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    sequence s_srst_req;
        wr_a && addr_i == `SCR_O_SRST && wdata_i[0] && !soft_reset_o;
    endsequence
    sequence s_srst_hold;
        soft_reset_o [*8];
    endsequence
    property p_srst_start;
        s_srst_req |=> s_srst_hold;
    endproperty
    a_srst_start: assert property (p_srst_start)
        else $error("soft reset did not start");
    property p_srst_len;
        soft_reset_o |-> srst_cnt < `SCR_SRST_CYC;
    endproperty
    a_srst_len: assert property (p_srst_len)
        else $error("soft reset held too long");
    property p_srst_end;
        $fell(soft_reset_o) |-> srst_cnt == `SCR_SRST_CYC;
    endproperty
    a_srst_end: assert property (p_srst_end)
        else $error("soft reset ended early");
    property p_grp_write;
        wr_i && addr_i == `SCR_O_GRP |=> group_select_o == $past(wdata_i);
    endproperty
    a_grp_write: assert property (p_grp_write)
        else $error("group selector not written");
    property p_flip;
        wr_a && addr_i == `SCR_O_FLIP |=> {vflip_o, hflip_o} == $past(wdata_i[1:0]);
    endproperty
    a_flip: assert property (p_flip)
        else $error("flip outputs wrong");
    property p_tm_mul;
        wr_a && addr_i == `SCR_O_TGM |=> timing_synth_multiplier_o == $past(wdata_i);
    endproperty
    a_tm_mul: assert property (p_tm_mul)
        else $error("timing multiplier wrong");
    property p_tm_div;
        wr_a && addr_i == `SCR_O_TGD |=> timing_synth_divider_o == $past(wdata_i[4:0]);
    endproperty
    a_tm_div: assert property (p_tm_div)
        else $error("timing divider wrong");
    property p_lk_mul;
        wr_a && addr_i == `SCR_O_LKM |=> link_synth_multiplier_o == $past(wdata_i);
    endproperty
    a_lk_mul: assert property (p_lk_mul)
        else $error("link multiplier wrong");
    property p_code;
        wr_a && addr_i == `SCR_O_BEL |=> blank_end_code_o[7:0] == $past(wdata_i);
    endproperty
    a_code: assert property (p_code)
        else $error("sync code low byte wrong");
    property p_far_wr;
        wr_i && far |=> $stable({vflip_o, hflip_o, timing_synth_multiplier_o});
    endproperty
    a_far_wr: assert property (p_far_wr)
        else $error("write reached an unselected group");
    property p_far_rd;
        rd_i && far |=> rdata_o == 8'h00;
    endproperty
    a_far_rd: assert property (p_far_rd)
        else $error("read reached an unselected group");
endmodule : scr_config_regs_assertions

bind scr_config_regs scr_config_regs_assertions u_scr_config_regs_assertions (
    .clk_sys_i, .resetn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .group_select_o, .soft_reset_o, .vflip_o, .hflip_o,
    .timing_synth_multiplier_o, .timing_synth_divider_o,
    .link_synth_multiplier_o, .blank_end_code_o
);

// file: scr_host_model.sv
// host controller model driving the register port
`timescale 1ns/1ps
`include "scr_regs.svh"

module scr_host_model (
    // clock
    input  wire logic       clk_sys_i,
    // register port
    output logic [7:0]      addr_o,
    output logic [7:0]      wdata_o,
    output logic            wr_o,
    output logic            rd_o,
    input  wire logic [7:0] rdata_i
);
    initial begin
        addr_o  = 8'h00;
        wdata_o = 8'h00;
        wr_o    = 1'b0;
        rd_o    = 1'b0;
    end

    // released lines show inverted values, never the last one
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (a == `SCR_O_LLH || a == `SCR_O_FLH) begin
            v[4] = 1'b1;
        end
        @(posedge clk_sys_i);
        addr_o  <= a;
        wdata_o <= v;
        wr_o    <= 1'b1;
        @(posedge clk_sys_i);
        wr_o    <= 1'b0;
        addr_o  <= ~a;
        wdata_o <= ~v;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys_i);
        addr_o <= a;
        rd_o   <= 1'b1;
        @(posedge clk_sys_i);
        rd_o   <= 1'b0;
        addr_o <= ~a;
        #1;
        d = rdata_i;
    endtask : rd_reg
endmodule : scr_host_model

// file: tb.sv
// self-checking bench for the sensor config register bank
`timescale 1ns/1ps
`include "scr_regs.svh"

`define CHK(got, want) begin \
    checks++; \
    if ((got) !== (want)) begin \
        fail_count++; \
        $display("Error at %0t got %h want %h", $time, got, want); \
    end \
end

module tb;
    localparam int N = 29;
    int adr_t [N] = '{'h03, 'h05, 'h06, 'h07, 'h08, 'h09, 'h1a, 'h20, 'h23,
        'h24, 'h25, 'h26, 'h27, 'h4e, 'h51, 'h52, 'h53, 'h54, 'h56, 'h57,
        'h58, 'h63, 'h64, 'h65, 'h66, 'h67, 'h68, 'h69, 'h6a};
    int rst_t [N] = '{'h00, 'h00, 'h08, 'h97, 'h04, 'h7c, 'h50, 'h00, 'h60,
        'h00, 'h00, 'h00, 'h00, 'h7a, 'h2c, 'h04, 'h2c, 'h04, 'h20, 'h50,
        'hf3, 'h0b, 'h60, 'h0a, 'hb0, 'h09, 'hd0, 'h08, 'h00};
    int msk_t [N] = '{'hff, 'h03, 'h1f, 'hff, 'h1f, 'hff, 'hff, 'h01, 'hff,
        'hff, 'hff, 'hff, 'hff, 'hff, 'hff, 'h1f, 'hff, 'h1f, 'hff, 'hff,
        'hff, 'h0f, 'hff, 'h0f, 'hff, 'h0f, 'hff, 'h0f, 'hff};
    int mdl [256];
    int checks, fail_count, cycles;
    logic        clk_sys_i, resetn_i, wr_i, rd_i, soft_reset_o;
    logic        vflip_o, hflip_o;
    logic [7:0]  addr_i, wdata_i, rdata_o, group_select_o;
    logic [7:0]  serial_port_ctrl_o, clock_synth_ctrl_o;
    logic [7:0]  pad_config_1_o, pad_config_2_o, pad_config_3_o;
    logic [7:0]  pad_config_4_o, pad_config_5_o;
    logic [7:0]  timing_synth_multiplier_o, link_synth_multiplier_o;
    logic [4:0]  timing_synth_divider_o, link_synth_divider_o;
    logic [7:0]  clock_divider_1_o, clock_divider_2_o, clock_divider_3_o;
    logic [12:0] line_length_o, frame_lines_o;
    logic [11:0] blank_end_code_o, blank_start_code_o;
    logic [11:0] active_end_code_o, active_start_code_o;
    wire [189:0] outs = {group_select_o, vflip_o, hflip_o, line_length_o,
        frame_lines_o, serial_port_ctrl_o, pad_config_1_o, pad_config_2_o,
        pad_config_3_o, pad_config_4_o, pad_config_5_o, clock_synth_ctrl_o,
        timing_synth_multiplier_o, timing_synth_divider_o,
        link_synth_multiplier_o, link_synth_divider_o, clock_divider_1_o,
        clock_divider_2_o, clock_divider_3_o, blank_end_code_o,
        blank_start_code_o, active_end_code_o, active_start_code_o};

    scr_config_regs u_scr_config_regs (.clk_sys_i, .resetn_i, .addr_i,
        .wdata_i, .wr_i, .rd_i, .rdata_o, .group_select_o, .soft_reset_o,
        .vflip_o, .hflip_o, .line_length_o, .frame_lines_o,
        .serial_port_ctrl_o, .pad_config_1_o, .pad_config_2_o,
        .pad_config_3_o, .pad_config_4_o, .pad_config_5_o,
        .clock_synth_ctrl_o, .timing_synth_multiplier_o,
        .timing_synth_divider_o, .link_synth_multiplier_o,
        .link_synth_divider_o, .clock_divider_1_o, .clock_divider_2_o,
        .clock_divider_3_o, .blank_end_code_o, .blank_start_code_o,
        .active_end_code_o, .active_start_code_o);
    scr_host_model u_scr_host_model (.clk_sys_i, .addr_o(addr_i),
        .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i), .rdata_i(rdata_o));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic print_verdict();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict

    task automatic rd_chk(input logic [7:0] a, input int e);
        logic [7:0] v;
        u_scr_host_model.rd_reg(a, v);
        `CHK(v, 8'(e))
    endtask : rd_chk

    task automatic chk_outs();
        logic [189:0] want;
        want = {8'(mdl['h03]), 2'(mdl['h05]), 5'(mdl['h06]), 8'(mdl['h07]),
            5'(mdl['h08]), 8'(mdl['h09]), 8'(mdl['h1a]), 8'(mdl['h23]),
            8'(mdl['h24]), 8'(mdl['h25]), 8'(mdl['h26]), 8'(mdl['h27]),
            8'(mdl['h4e]), 8'(mdl['h51]), 5'(mdl['h52]), 8'(mdl['h53]),
            5'(mdl['h54]), 8'(mdl['h56]), 8'(mdl['h57]), 8'(mdl['h58]),
            4'(mdl['h63]), 8'(mdl['h64]), 4'(mdl['h65]), 8'(mdl['h66]),
            4'(mdl['h67]), 8'(mdl['h68]), 4'(mdl['h69]), 8'(mdl['h6a])};
        `CHK(outs, want)
    endtask : chk_outs

    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end

    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 6000) begin
            fail_count++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        int i, a, d, n;
        resetn_i = 1'b0;
        i = $urandom(91);
        for (i = 0; i < N; i++) mdl[adr_t[i]] = rst_t[i];
        repeat (3) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        for (i = 0; i < N; i++) begin
            rd_chk(8'(adr_t[i]), rst_t[i]);
        end
        chk_outs();
        for (n = 0; n < 80; n++) begin
            i = $urandom_range(N - 1, 1);
            if (i == 7) continue;
            a = adr_t[i];
            d = $urandom_range(255, 0);
            if (a == 'h06 || a == 'h08) d = d | 'h10;
            mdl[a] = d & msk_t[i];
            u_scr_host_model.wr_reg(8'(a), 8'(d));
            rd_chk(8'(a), mdl[a]);
            chk_outs();
        end
        u_scr_host_model.wr_reg(8'h04, 8'h5a);
        rd_chk(8'h04, 0);
        d = $urandom_range(255, 1);
        u_scr_host_model.wr_reg(8'h03, 8'(d));
        mdl['h03] = d;
        u_scr_host_model.wr_reg(8'h05, ~8'(mdl['h05]));
        rd_chk(8'h05, 0);
        rd_chk(8'h03, d);
        chk_outs();
        u_scr_host_model.wr_reg(8'h03, 8'h00);
        mdl['h03] = 0;
        rd_chk(8'h05, mdl['h05]);
        u_scr_host_model.wr_reg(8'h20, 8'h00);
        rd_chk(8'h20, 0);
        `CHK(soft_reset_o, 1'b0)
        u_scr_host_model.wr_reg(8'h20, 8'h01);
        #1;
        n = 0;
        while (soft_reset_o === 1'b1 && n < 200) begin
            n++;
            @(posedge clk_sys_i);
            #1;
        end
        `CHK(n, `SCR_SRST_CYC)
        @(posedge clk_sys_i);
        rd_chk(8'h20, 0);
        u_scr_host_model.wr_reg(8'h20, 8'h01);
        rd_chk(8'h20, 1);
        n = 0;
        while (soft_reset_o !== 1'b0 && n < 200) begin
            n++;
            @(posedge clk_sys_i);
            #1;
        end
        @(posedge clk_sys_i);
        rd_chk(8'h20, 0);
        chk_outs();
        print_verdict();
    end
endmodule : tb
